// ---- src/afmm_params.svh ----
`ifndef AFMM_PARAMS_SVH
`define AFMM_PARAMS_SVH

// Clock and timing
`define AFMM_CLK_MHZ            125
`define AFMM_OVERLOAD_TIME_US   2600
`define AFMM_OVERLOAD_CYCLES    (`AFMM_OVERLOAD_TIME_US * `AFMM_CLK_MHZ)
`define AFMM_STUCK_CYCLES_DEF   1024
`define AFMM_STARTUP_CYCLES_DEF 256

// Register byte offsets
`define AFMM_OFS_CTRL   4'h0
`define AFMM_OFS_STATUS 4'h4
`define AFMM_OFS_MODE   4'h8

// Control fields
`define AFMM_CTRL_LATCHED_OC 0
`define AFMM_CTRL_DC_PROT    1
`define AFMM_CTRL_RESET      2'h0

// Status fields
`define AFMM_ST_FAULT     0
`define AFMM_ST_TRIP      1
`define AFMM_ST_UV        2
`define AFMM_ST_ALL_STUCK 3
`define AFMM_ST_MODE_OK   4
`define AFMM_ST_RUN       5
`define AFMM_ST_WARN      6
`define AFMM_ST_OVL_LSB   8
`define AFMM_ST_STUCK_LSB 12
`define AFMM_ST_BST_LSB   16

`endif

// ---- src/afmm_pkg.sv ----
package afmm_pkg;

   // Mode pin codes, mode_sel_2..mode_sel_0
   typedef enum logic [2:0] {
      AFMM_BTL_AD_2N  = 3'h0,
      AFMM_BTL_AD_1N  = 3'h1,
      AFMM_BTL_BD_2N  = 3'h2,
      AFMM_PARALLEL_BRIDGED_OUTPUT_AD_2N = 3'h4,
      AFMM_SE4_AD_1N  = 3'h5
   } afmm_mode_t;

   // Gray along hold -> start -> run
   typedef enum logic [1:0] {
      AFMM_HOLD  = 2'h0,
      AFMM_START = 2'h1,
      AFMM_RUN   = 2'h3
   } afmm_state_t;

endpackage : afmm_pkg

// ---- src/afmm_top.sv ----
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "afmm_params.svh"

module afmm_top #(
   parameter int unsigned STUCK_CYCLES    = `AFMM_STUCK_CYCLES_DEF,
   parameter int unsigned OVERLOAD_CYCLES = `AFMM_OVERLOAD_CYCLES,
   parameter int unsigned STARTUP_CYCLES  = `AFMM_STARTUP_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Device pins, asynchronous
   input  wire logic [3:0]  pwm_in_i,
   input  wire logic        reset_pin_n_i,
   input  wire logic [2:0]  mode_sel_i,
   // Sense inputs from the analog side, asynchronous
   input  wire logic        stage_supply_uv_i,
   input  wire logic        gate_supply_uv_i,
   input  wire logic        analog_supply_uv_i,
   input  wire logic        logic_supply_por_i,
   input  wire logic [3:0]  bootstrap_cap_uv_i,
   input  wire logic        thermal_warn_i,
   input  wire logic        thermal_trip_i,
   input  wire logic [3:0]  overcurrent_i,
   input  wire logic [1:0]  dc_unbalance_i,
   input  wire logic        loop_saturate_i,
   // Gate drive, per half bridge
   output logic      [3:0]  high_side_on_o,
   output logic      [3:0]  low_side_on_o,
   output logic      [3:0]  weak_pulldown_o,
   // Open-drain flags, pulled low while enable is high
   output logic             fault_n_o,
   output logic             fault_n_oe_o,
   output logic             thermal_warn_n_o,
   output logic             thermal_warn_n_oe_o,
   output logic             clip_n_o,
   output logic             clip_n_oe_o
);

   localparam int unsigned SYNC_W = 25;
   localparam int unsigned SW     = $clog2(STUCK_CYCLES + 1);
   localparam int unsigned OW     = $clog2(OVERLOAD_CYCLES + 1);
   localparam int unsigned TW     = $clog2(STARTUP_CYCLES + 1);

   // Counters need room for at least one step
   if (STUCK_CYCLES < 2 || OVERLOAD_CYCLES < 2 || STARTUP_CYCLES < 1) begin : g_bad_count
      $error("afmm_top: counts too small");
   end

   logic [SYNC_W-1:0] sync_meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_meta_ff <= '0;
         sync_ff      <= '0;
      end else begin
         sync_meta_ff <= {pwm_in_i, reset_pin_n_i, mode_sel_i, stage_supply_uv_i,
                          gate_supply_uv_i, analog_supply_uv_i, logic_supply_por_i,
                          bootstrap_cap_uv_i, thermal_warn_i, thermal_trip_i,
                          overcurrent_i, dc_unbalance_i, loop_saturate_i};
         sync_ff      <= sync_meta_ff;
      end
   end

   logic [3:0] pwm_s;
   logic       rst_pin_s;
   logic [2:0] mode_pin_s;
   logic       uv_s;
   logic       por_s;
   logic [3:0] bst_uv_s;
   logic       warn_s;
   logic       trip_s;
   logic [3:0] oc_s;
   logic [1:0] dc_s;
   logic       sat_s;
   assign pwm_s      = sync_ff[24:21];
   assign rst_pin_s  = sync_ff[20];
   assign mode_pin_s = sync_ff[19:17];
   assign uv_s       = sync_ff[16] | sync_ff[15] | sync_ff[14];
   assign por_s      = sync_ff[13];
   assign bst_uv_s   = sync_ff[12:9];
   assign warn_s     = sync_ff[8];
   assign trip_s     = sync_ff[7];
   assign oc_s       = sync_ff[6:3];
   assign dc_s       = sync_ff[2:1];
   assign sat_s      = sync_ff[0];

   // Registers
   logic [1:0]  ctrl_ff;
   logic [2:0]  mode_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] status;

   // Reset pin edge and startup sequencer
   logic                 rst_prev_ff;
   logic                 rst_rise;
   afmm_pkg::afmm_state_t state_ff;
   logic [TW-1:0]        start_cnt_ff;
   logic                 running;
   assign rst_rise = rst_pin_s & ~rst_prev_ff;
   assign running  = (state_ff == afmm_pkg::AFMM_RUN);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_prev_ff <= 1'b0;
      end else begin
         rst_prev_ff <= rst_pin_s;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff     <= afmm_pkg::AFMM_HOLD;
         start_cnt_ff <= '0;
      end else if (!rst_pin_s) begin
         state_ff     <= afmm_pkg::AFMM_HOLD;
         start_cnt_ff <= '0;
      end else begin
         case (state_ff)
            afmm_pkg::AFMM_HOLD: begin
               if (rst_rise) begin
                  state_ff <= afmm_pkg::AFMM_START;
               end
            end
            afmm_pkg::AFMM_START: begin
               if (start_cnt_ff == TW'(STARTUP_CYCLES - 1)) begin
                  state_ff <= afmm_pkg::AFMM_RUN;
               end
               start_cnt_ff <= start_cnt_ff + 1'b1;
            end
            afmm_pkg::AFMM_RUN: begin
               state_ff <= afmm_pkg::AFMM_RUN;
            end
            default: begin
               state_ff <= afmm_pkg::AFMM_HOLD;
            end
         endcase
      end
   end

   // Mode sampled once, at the reset rise
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_ff <= 3'h0;
      end else if (rst_rise) begin
         mode_ff <= mode_pin_s;
      end
   end

   // Legal codes only; others keep the stage Hi-Z
   logic mode_ok;
   logic three_level;
   logic single_ended;
   logic parallel;
   assign mode_ok      = mode_ff inside {afmm_pkg::AFMM_BTL_AD_2N, afmm_pkg::AFMM_BTL_AD_1N,
                                         afmm_pkg::AFMM_BTL_BD_2N, afmm_pkg::AFMM_PARALLEL_BRIDGED_OUTPUT_AD_2N,
                                         afmm_pkg::AFMM_SE4_AD_1N};
   assign three_level  = (mode_ff == afmm_pkg::AFMM_BTL_BD_2N);
   assign single_ended = (mode_ff == afmm_pkg::AFMM_SE4_AD_1N);
   assign parallel     = (mode_ff == afmm_pkg::AFMM_PARALLEL_BRIDGED_OUTPUT_AD_2N);

   // Per half bridge: source input, inversion and channel grouping
   logic [1:0] src_sel [4];
   logic [3:0] src_inv;
   logic [3:0] grp_mask [4];
   logic [3:0] used_in;
   always_comb begin
      used_in = 4'hf;
      for (int x = 0; x < 4; x++) begin
         src_sel[x]  = 2'(x);
         src_inv[x]  = 1'b0;
         grp_mask[x] = 4'h3 << (x & 2);
         case (mode_ff)
            afmm_pkg::AFMM_BTL_AD_1N: begin
               // Pair driven complementary from one input
               src_sel[x] = 2'(x & 2);
               src_inv[x] = x[0];
            end
            afmm_pkg::AFMM_PARALLEL_BRIDGED_OUTPUT_AD_2N: begin
               src_sel[x]  = 2'(x & 1);
               grp_mask[x] = 4'hf;
            end
            afmm_pkg::AFMM_SE4_AD_1N: begin
               grp_mask[x] = 4'h1 << x;
            end
            default: begin
               src_sel[x] = 2'(x);
            end
         endcase
      end
      if (mode_ff == afmm_pkg::AFMM_BTL_AD_1N) begin
         used_in = 4'h5;
      end else if (parallel) begin
         used_in = 4'h3;
      end
   end

   // Stuck input: no edge within the frame window
   logic [3:0]    pwm_prev_ff;
   logic [3:0]    pwm_rise;
   logic [3:0]    stuck_ff;
   logic [SW-1:0] idle_cnt_ff [4];
   assign pwm_rise = pwm_s & ~pwm_prev_ff;

   for (genvar g = 0; g < 4; g++) begin : g_stuck
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            idle_cnt_ff[g] <= '0;
            stuck_ff[g]    <= 1'b1;
         end else if (pwm_s[g] != pwm_prev_ff[g]) begin
            idle_cnt_ff[g] <= '0;
            stuck_ff[g]    <= 1'b0;
         end else if (idle_cnt_ff[g] == SW'(STUCK_CYCLES)) begin
            stuck_ff[g]    <= 1'b1;
         end else begin
            idle_cnt_ff[g] <= idle_cnt_ff[g] + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwm_prev_ff <= 4'h0;
      end else begin
         pwm_prev_ff <= pwm_s;
      end
   end

   // All used inputs idle counts as a global stop
   logic all_stuck;
   assign all_stuck = ((stuck_ff & used_in) == used_in);

   // DC protection only for two-level bridged use
   logic       dc_active;
   logic [3:0] oc_eff;
   assign dc_active = ctrl_ff[`AFMM_CTRL_DC_PROT] & ~three_level & ~single_ended & mode_ok;
   assign oc_eff    = oc_s | ({4{dc_active}} & {dc_s[1], dc_s[1], dc_s[0], dc_s[0]});

   logic [OW-1:0] ovl_cnt_ff [4];
   logic [3:0]    ovl_latch_ff;
   logic [3:0]    flip_ff;
   logic          clr_latch;
   // Reset low or power-on clear drops the latches
   assign clr_latch = ~rst_pin_s | por_s;

   for (genvar g = 0; g < 4; g++) begin : g_ovl
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            ovl_cnt_ff[g]   <= '0;
            ovl_latch_ff[g] <= 1'b0;
         end else if (clr_latch) begin
            ovl_cnt_ff[g]   <= '0;
            ovl_latch_ff[g] <= 1'b0;
         end else if (running && oc_eff[g]) begin
            if (ctrl_ff[`AFMM_CTRL_LATCHED_OC]) begin
               ovl_latch_ff[g] <= 1'b1;
            end else if (ovl_cnt_ff[g] == OW'(OVERLOAD_CYCLES)) begin
               ovl_latch_ff[g] <= 1'b1;
            end else begin
               ovl_cnt_ff[g] <= ovl_cnt_ff[g] + 1'b1;
            end
         end else if (ovl_cnt_ff[g] != '0) begin
            ovl_cnt_ff[g] <= ovl_cnt_ff[g] - 1'b1;
         end
      end

      // Limiting toggles once per input frame, half the switching rate
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            flip_ff[g] <= 1'b0;
         end else if (pwm_rise[src_sel[g]]) begin
            flip_ff[g] <= ~flip_ff[g];
         end
      end
   end

   logic trip_latch_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trip_latch_ff <= 1'b0;
      end else if (!rst_pin_s) begin
         trip_latch_ff <= 1'b0;
      end else if (trip_s) begin
         trip_latch_ff <= 1'b1;
      end
   end

   logic global_uv;
   logic global_off;
   logic [3:0] hb_kill;
   logic [3:0] chan_kill;
   assign global_uv  = uv_s | por_s;
   // Global stop of every half bridge
   // Pin low stops drive in the same cycle as the flag mask
   assign global_off = global_uv | trip_latch_ff | all_stuck | ~mode_ok | ~running | ~rst_pin_s;

   always_comb begin
      for (int x = 0; x < 4; x++) begin
         hb_kill[x] = ovl_latch_ff[x] | stuck_ff[src_sel[x]];
      end
      for (int x = 0; x < 4; x++) begin
         // Fault spreads only within its own channel
         chan_kill[x] = |(hb_kill & grp_mask[x]);
      end
   end

   // Gate drive
   logic [3:0] nxt_hs;
   logic [3:0] nxt_ls;
   logic [3:0] hs_ff;
   logic [3:0] ls_ff;
   logic [3:0] pd_ff;
   always_comb begin
      for (int x = 0; x < 4; x++) begin
         logic drv;
         drv = ~pwm_s[src_sel[x]] ^ src_inv[x];
         if (oc_eff[x] && !ctrl_ff[`AFMM_CTRL_LATCHED_OC]) begin
            drv = flip_ff[x];
         end
         // Off and not running means Hi-Z
         if (global_off || chan_kill[x]) begin
            nxt_hs[x] = 1'b0;
            nxt_ls[x] = 1'b0;
         end else begin
            // Bootstrap low blocks only the high side
            nxt_hs[x] = drv & ~bst_uv_s[x];
            nxt_ls[x] = ~drv;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hs_ff <= 4'h0;
         ls_ff <= 4'h0;
         pd_ff <= 4'h0;
      end else begin
         hs_ff <= nxt_hs;
         ls_ff <= nxt_ls;
         // Pulldowns under reset in every mode but single-ended
         pd_ff <= {4{~rst_pin_s & ~single_ended}};
      end
   end

   // Flags
   logic fault_ff;
   logic warn_ff;
   logic clip_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_ff <= 1'b0;
         warn_ff  <= 1'b0;
         clip_ff  <= 1'b0;
      end else begin
         // Reported faults, masked by reset low
         fault_ff <= rst_pin_s & (global_uv | trip_latch_ff | (|ovl_latch_ff));
         // Warning has its own flag only
         warn_ff  <= warn_s;
         // Clip while the loop skips pulses
         clip_ff  <= sat_s & running;
      end
   end

   // Avalon slave: one wait state, answer on the second edge
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;

   assign status = {11'h0, warn_s, bst_uv_s, stuck_ff, ovl_latch_ff, 1'b0, warn_ff,
                    running, mode_ok, all_stuck, global_uv, trip_latch_ff, fault_ff};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
         if (avs_read_i && !ack_ff) begin
            case (avs_address_i)
               `AFMM_OFS_CTRL:   rdata_ff <= {30'h0, ctrl_ff};
               `AFMM_OFS_STATUS: rdata_ff <= status;
               `AFMM_OFS_MODE:   rdata_ff <= {29'h0, mode_ff};
               default:          rdata_ff <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_ff <= `AFMM_CTRL_RESET;
      end else if (avs_write_i && ack_ff && avs_byteenable_i[0]
                   && avs_address_i == `AFMM_OFS_CTRL) begin
         ctrl_ff <= avs_writedata_i[1:0];
      end
   end

   // Outputs
   assign avs_readdata_o      = rdata_ff;
   assign high_side_on_o      = hs_ff;
   assign low_side_on_o       = ls_ff;
   assign weak_pulldown_o     = pd_ff;
   assign fault_n_o           = 1'b0;
   assign fault_n_oe_o        = fault_ff;
   assign thermal_warn_n_o    = 1'b0;
   assign thermal_warn_n_oe_o = warn_ff;
   assign clip_n_o            = 1'b0;
   assign clip_n_oe_o         = clip_ff;

endmodule : afmm_top
`default_nettype wire

// ---- test/afmm_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module afmm_chk (
   input wire logic       clk_i,
   input wire logic       arst_n_i,
   input wire logic       reset_pin_n_i,
   input wire logic       stage_supply_uv_i,
   input wire logic       logic_supply_por_i,
   input wire logic [3:0] bootstrap_cap_uv_i,
   input wire logic       thermal_warn_i,
   input wire logic       loop_saturate_i,
   input wire logic [3:0] high_side_on_o,
   input wire logic [3:0] low_side_on_o,
   input wire logic       fault_n_oe_o,
   input wire logic       thermal_warn_n_oe_o,
   input wire logic       clip_n_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // Four samples span both sync stages and the output register
   sequence s_pin_low;
      !reset_pin_n_i [*4];
   endsequence
   sequence s_uv_run;
      (stage_supply_uv_i && reset_pin_n_i) [*4];
   endsequence
   sequence s_por_run;
      (logic_supply_por_i && reset_pin_n_i) [*4];
   endsequence

   property p_flag_masked;
      s_pin_low |-> !fault_n_oe_o;
   endproperty
   a_flag_masked: assert property (p_flag_masked)
      else $error("fault flag set while reset pin low");
   property p_hiz_reset;
      s_pin_low |-> (high_side_on_o == 4'h0) && (low_side_on_o == 4'h0);
   endproperty
   a_hiz_reset: assert property (p_hiz_reset)
      else $error("bridge driven while reset pin low");
   property p_uv_global;
      s_uv_run |-> fault_n_oe_o && ((high_side_on_o | low_side_on_o) == 4'h0);
   endproperty
   a_uv_global: assert property (p_uv_global)
      else $error("supply fault did not stop all bridges");
   property p_por_global;
      s_por_run |-> fault_n_oe_o && (high_side_on_o == 4'h0);
   endproperty
   a_por_global: assert property (p_por_global)
      else $error("power-on clear did not stop bridges");
   property p_warn_on;
      thermal_warn_i [*4] |-> thermal_warn_n_oe_o;
   endproperty
   a_warn_on: assert property (p_warn_on)
      else $error("warning flag missing");
   property p_warn_off;
      !thermal_warn_i [*4] |-> !thermal_warn_n_oe_o;
   endproperty
   a_warn_off: assert property (p_warn_off)
      else $error("warning flag without cause");
   property p_bst_off;
      bootstrap_cap_uv_i[3] [*4] |-> !high_side_on_o[3];
   endproperty
   a_bst_off: assert property (p_bst_off)
      else $error("high side on with low bootstrap");
   property p_clip_off;
      !loop_saturate_i [*4] |-> !clip_n_oe_o;
   endproperty
   a_clip_off: assert property (p_clip_off)
      else $error("clip flag without saturation");
endmodule : afmm_chk

bind afmm_top afmm_chk u_chk (.clk_i, .arst_n_i, .reset_pin_n_i, .stage_supply_uv_i,
   .logic_supply_por_i, .bootstrap_cap_uv_i, .thermal_warn_i, .loop_saturate_i,
   .high_side_on_o, .low_side_on_o, .fault_n_oe_o, .thermal_warn_n_oe_o, .clip_n_oe_o);
`default_nettype wire

// ---- test/afmm_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module afmm_far_model #(
   parameter int HOLD_CYC = 8
) (
   input  wire logic       clk_i,
   input  wire logic [3:0] pwm_en_i,
   input  wire logic       fault_n_oe_i,
   input  wire logic       thermal_warn_n_oe_i,
   output logic      [3:0] pwm_o,
   output logic            reset_pin_n_o,
   output logic      [2:0] mode_sel_o
);
   logic [3:0] cnt_ff;
   initial begin
      cnt_ff = 4'h0;
      reset_pin_n_o = 1'b0;
      mode_sel_o = 3'h0;
   end
   always @(posedge clk_i) cnt_ff <= cnt_ff + 4'h1;
   assign pwm_o = {cnt_ff[3], cnt_ff[2], ~cnt_ff[3], cnt_ff[3] ^ cnt_ff[2]} & pwm_en_i;

   task automatic pin_low();
      reset_pin_n_o <= 1'b0;
   endtask : pin_low

   task automatic pin_high(input logic [2:0] m);
      int n;
      n = 0;
      // wait after flag falls, never release while hot
      while (n < HOLD_CYC) begin
         @(posedge clk_i);
         n = (fault_n_oe_i || thermal_warn_n_oe_i) ? 0 : n + 1;
      end
      mode_sel_o <= m;
      @(posedge clk_i);
      reset_pin_n_o <= 1'b1;
   endtask : pin_high

   task automatic restart(input logic [2:0] m);
      pin_low();
      pin_high(m);
   endtask : restart
endmodule : afmm_far_model
`default_nettype wire

// ---- test/amp_fault_mode_manager_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module amp_fault_mode_manager_tb;
   logic        clk, arst_n, rd, wr, warn, trip, sat, rpin;
   logic [3:0]  adr, be, bootstrap_cap, oc, pwm_en, pwm, h1, h2, h3, sup, hs, ls, wpd;
   logic [31:0] wd, rdat, q;
   logic [2:0]  mode;
   logic [1:0]  dc;
   logic        wreq, f_oe, w_oe, c_oe, f_d, w_d, c_d;
   int          fail_count, check_count;

   afmm_top #(.STUCK_CYCLES(16), .OVERLOAD_CYCLES(20), .STARTUP_CYCLES(4)) DUT (
      .clk_i(clk), .arst_n_i(arst_n), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pwm_in_i(pwm),
      .reset_pin_n_i(rpin), .mode_sel_i(mode), .stage_supply_uv_i(sup[0]),
      .gate_supply_uv_i(sup[1]), .analog_supply_uv_i(sup[2]),
      .logic_supply_por_i(sup[3]), .bootstrap_cap_uv_i(bootstrap_cap), .thermal_warn_i(warn),
      .thermal_trip_i(trip), .overcurrent_i(oc), .dc_unbalance_i(dc),
      .loop_saturate_i(sat), .high_side_on_o(hs), .low_side_on_o(ls),
      .weak_pulldown_o(wpd), .fault_n_o(f_d), .fault_n_oe_o(f_oe),
      .thermal_warn_n_o(w_d), .thermal_warn_n_oe_o(w_oe), .clip_n_o(c_d),
      .clip_n_oe_o(c_oe));

   afmm_far_model #(.HOLD_CYC(8)) u_far (.clk_i(clk), .pwm_en_i(pwm_en),
      .fault_n_oe_i(f_oe), .thermal_warn_n_oe_i(w_oe), .pwm_o(pwm),
      .reset_pin_n_o(rpin), .mode_sel_o(mode));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Input history matching the three-edge pin latency
   always @(posedge clk) begin
      h1 <= pwm;
      h2 <= h1;
      h3 <= h2;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   // Waits as long as the slave asks; only the watchdog ends a hang
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   function automatic logic [3:0] src(input logic [2:0] m, input logic [3:0] p);
      case (m)
         3'h1: return {~p[2], p[2], ~p[0], p[0]};
         3'h4: return {p[1], p[0], p[1], p[0]};
         default: return p;
      endcase
   endfunction : src

   task automatic chk_drive(input logic [2:0] m, input logic [3:0] live);
      repeat (16) begin
         @(negedge clk);
         `CHK(hs, ~src(m, h3) & live)
         `CHK(ls, src(m, h3) & live)
      end
      @(posedge clk);
   endtask : chk_drive

   task automatic results();
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results

   initial begin
      wt(20000);
      fail_count++;
      results();
   end

   initial begin
      logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
      fail_count = 0;
      check_count = 0;
      {arst_n, rd, wr, warn, trip, sat} = 6'h0;
      {adr, bootstrap_cap, oc, sup} = 16'h0;
      be = 4'hf;
      pwm_en = 4'hf;
      wd = 32'h0;
      dc = 2'h0;
      wt(3);
      arst_n <= 1'b1;
      wt(1);
      `CHK({f_d, w_d, c_d}, 3'h0)
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, 4'h0, 32'h3);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h3)
      be <= 4'he;
      bus(1'b1, 4'h0, 32'h0);
      be <= 4'hf;
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h3)
      bus(1'b0, 4'hc, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, 4'h0, 32'h0);
      sup <= 4'h1;
      wt(6);
      `CHK(f_oe, 1'b0)
      `CHK({hs, ls}, 8'h0)
      sup <= 4'h0;
      foreach (modes[i]) begin
         u_far.restart(modes[i]);
         wt(20);
         bus(1'b0, 4'h8, 32'h0);
         `CHK(q[2:0], modes[i])
         chk_drive(modes[i], 4'hf);
         u_far.pin_low();
         wt(6);
         `CHK(wpd, (modes[i] == 3'h5) ? 4'h0 : 4'hf)
      end
      u_far.pin_high(3'h3);
      wt(20);
      `CHK({hs, ls}, 8'h0)
      bus(1'b0, 4'h4, 32'h0);
      `CHK(q[4], 1'b0)
      u_far.restart(3'h5);
      wt(20);
      pwm_en <= 4'hb;
      wt(30);
      chk_drive(3'h5, 4'hb);
      `CHK(f_oe, 1'b0)
      pwm_en <= 4'h0;
      wt(30);
      `CHK({hs, ls, f_oe}, 9'h0)
      pwm_en <= 4'hf;
      wt(30);
      oc <= 4'h1;
      wt(30);
      oc <= 4'h0;
      wt(10);
      `CHK(f_oe, 1'b1)
      chk_drive(3'h5, 4'he);
      bus(1'b0, 4'h4, 32'h0);
      `CHK(q[8], 1'b1)
      u_far.restart(3'h5);
      wt(20);
      `CHK(f_oe, 1'b0)
      oc <= 4'h1;
      wt(8);
      `CHK({f_oe, hs[0] ^ ls[0]}, 2'h1)
      oc <= 4'h0;
      wt(30);
      `CHK(f_oe, 1'b0)
      bus(1'b1, 4'h0, 32'h1);
      oc <= 4'h2;
      wt(2);
      oc <= 4'h0;
      wt(8);
      `CHK(f_oe, 1'b1)
      chk_drive(3'h5, 4'hd);
      bus(1'b1, 4'h0, 32'h0);
      u_far.restart(3'h5);
      wt(20);
      trip <= 1'b1;
      wt(6);
      trip <= 1'b0;
      wt(10);
      `CHK({f_oe, hs, ls}, 9'h100)
      u_far.restart(3'h5);
      wt(20);
      `CHK(f_oe, 1'b0)
      warn <= 1'b1;
      wt(5);
      `CHK({w_oe, f_oe}, 2'h2)
      chk_drive(3'h5, 4'hf);
      warn <= 1'b0;
      wt(5);
      for (int i = 0; i < 4; i++) begin
         sup <= 4'h1 << i;
         wt(6);
         `CHK({f_oe, hs}, 5'h10)
         sup <= 4'h0;
         wt(30);
         `CHK(f_oe, 1'b0)
         chk_drive(3'h5, 4'hf);
      end
      bootstrap_cap <= 4'h8;
      wt(5);
      `CHK({hs[3], f_oe}, 2'h0)
      bootstrap_cap <= 4'h0;
      sat <= 1'b1;
      wt(5);
      `CHK(c_oe, 1'b1)
      sat <= 1'b0;
      wt(5);
      `CHK(c_oe, 1'b0)
      u_far.restart(3'h2);
      bus(1'b1, 4'h0, 32'h2);
      wt(20);
      dc <= 2'h1;
      wt(40);
      `CHK(f_oe, 1'b0)
      dc <= 2'h0;
      u_far.restart(3'h0);
      wt(20);
      dc <= 2'h1;
      wt(40);
      `CHK(f_oe, 1'b1)
      dc <= 2'h0;
      `CHK({f_d, w_d, c_d}, 3'h0)
      results();
   end
endmodule : amp_fault_mode_manager_tb
`default_nettype wire
